//--- common/irq_share_params.svh
// constants for the shared interrupt irq_strobe_a block: offsets, reset values, timing
// assumes a single 50 MHz core clock and a 16-bit host I/O address
`ifndef IRQ_SHARE_PARAMS_SVH
`define IRQ_SHARE_PARAMS_SVH

// clock rate and shared request pulse timing
`define CLK_MHZ       50
`define PULSE_NS      1000
`define PULSE_CYC     ((`PULSE_NS * `CLK_MHZ + 999) / 1000)
`define PULSE_CW      8

// register byte offsets on the AXI4-Lite slave
`define REG_CFG       8'h00
`define REG_STAT      8'h04

// configuration reset: polled operation, default legacy line map
`define CFG_RST       24'h004B00
`define DFLT_MAP      8'h4B

// AXI response codes
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

// IRQ line index: 0=IRQ3 1=IRQ4 2=IRQ10 3=IRQ11 4=IRQ12 5=IRQ14 6=IRQ15
`define LINE_NUM      7
`define SINGLE_NUM    4

// host I/O irq_strobe_a addresses, one per shareable line
`define IRQ_STROBE_A_IRQ3    16'h02F3
`define IRQ_STROBE_A_IRQ4    16'h02F4
`define IRQ_STROBE_A_IRQ10   16'h06F2
`define IRQ_STROBE_A_IRQ11   16'h06F3
`define IRQ_STROBE_A_IRQ12   16'h06F4
`define IRQ_STROBE_A_IRQ14   16'h06F6
`define IRQ_STROBE_A_IRQ15   16'h06F7

`endif

//--- common/irq_share_pkg.sv
// types for the shared interrupt irq_strobe_a block
// assumes irq_share_params.svh is on the include path
`include "irq_share_params.svh"

package irq_share_pkg;

  // static routing configuration, one register
  typedef struct packed {
    logic [3:0] legacy;      // port sits at a legacy serial address
    logic       sharedEn;    // shared request logic connected
    logic [2:0] sharedLine;  // line index of the shared request
    logic [7:0] portLine;    // 2-bit single line code per port
    logic [3:0] lineConn;    // single line connect for IRQ3,4,10,11
    logic [3:0] singleSel;   // per-port single interrupt select
  } cfg_t;

  typedef enum logic [1:0] {
    PS_ARMED,
    PS_PULSE,
    PS_BLOCKED
  } pulse_state_t;

  typedef struct packed {
    pulse_state_t          st;
    logic [`PULSE_CW-1:0]  cnt;
    logic                  low;
    logic                  armed;
  } pulse_reg_t;

  typedef struct packed {
    cfg_t        cfg;
    logic        awReady;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wReady;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [2:0]  iorSync;
    logic [2:0]  iowSync;
    logic [15:0] addrS1;
    logic [15:0] addrS2;
    logic [6:0]  irqOut;
    logic [6:0]  irqOe;
  } top_reg_t;

endpackage : irq_share_pkg

//--- dv/host_model.sv
// host side model: I/O strobes for irq_strobe_a and an edge-triggered interrupt controller
// assumes IRQ lines are pulled up when no party drives them
`timescale 1ns/1ps

module host_model (
  input  wire logic        core_clk,
  input  wire logic [6:0]  irqOut,
  input  wire logic [6:0]  irqOe,
  output logic      [15:0] hostAddr,
  output logic             hostIorN,
  output logic             hostIowN
);
  logic [6:0] lvl;
  logic [6:0] prev = 7'h7F;
  int         falls [7] = '{default: 0};
  int         lowLen [7] = '{default: 0};
  int         run [7] = '{default: 0};

  initial begin
    hostAddr = 16'h0000;
    hostIorN = 1'b1;
    hostIowN = 1'b1;
  end

  // wire level: pull-up wins when the device lets go
  assign lvl = (irqOut & irqOe) | ~irqOe;

  // controller counts leading edges only, and measures each low phase
  always @(posedge core_clk) begin
    for (int i = 0; i < 7; i++) begin
      if (prev[i] && !lvl[i]) falls[i]++;
      if (!lvl[i]) run[i]++;
      else if (run[i] != 0) begin
        lowLen[i] = run[i];
        run[i] = 0;
      end
    end
    prev <= lvl;
  end

  // dummy access after service and EOI; address released to its inverse afterwards
  task automatic io(input logic [15:0] a, input logic wr);
    hostAddr <= a;
    repeat (3) @(posedge core_clk);
    if (wr) hostIowN <= 1'b0;
    else hostIorN <= 1'b0;
    repeat (3) @(posedge core_clk);
    hostIowN <= 1'b1;
    hostIorN <= 1'b1;
    repeat (3) @(posedge core_clk);
    hostAddr <= ~a;
  endtask : io
endmodule : host_model

//--- dv/shared_irq_irq_strobe_a_logic_bench.sv
// bench for the interrupt routing block: AXI4-Lite setup, port requests, host irq_strobe_a
// assumes host_model is compiled before it and the params header is on the path
`timescale 1ns/1ps
`include "irq_share_params.svh"

module shared_irq_irq_strobe_a_logic_bench;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awAddr = 8'h00;
  logic        awValid = 1'b0;
  logic        awReady;
  logic [31:0] wData = 32'h0;
  logic        wValid = 1'b0;
  logic        wReady;
  logic [1:0]  bResp;
  logic        bValid;
  logic        bReady = 1'b0;
  logic [7:0]  arAddr = 8'h00;
  logic        arValid = 1'b0;
  logic        arReady;
  logic [31:0] rData;
  logic [1:0]  rResp;
  logic        rValid;
  logic        rReady = 1'b0;
  logic [3:0]  portReq = 4'h0;
  logic [15:0] hostAddr;
  logic        hostIorN;
  logic        hostIowN;
  logic [6:0]  irqOut;
  logic [6:0]  irqOe;
  int          nFail = 0;
  int          checked = 0;
  logic [15:0] ra [7] = '{`IRQ_STROBE_A_IRQ3, `IRQ_STROBE_A_IRQ4, `IRQ_STROBE_A_IRQ10, `IRQ_STROBE_A_IRQ11,
                          `IRQ_STROBE_A_IRQ12, `IRQ_STROBE_A_IRQ14, `IRQ_STROBE_A_IRQ15};
  int          lm [4] = '{3, 2, 0, 1};

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  shared_irq_irq_strobe_a_logic DUT (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .portReq(portReq), .hostAddr(hostAddr), .hostIorN(hostIorN), .hostIowN(hostIowN),
    .irqOut(irqOut), .irqOe(irqOe)
  );

  host_model host (
    .core_clk(core_clk), .irqOut(irqOut), .irqOe(irqOe),
    .hostAddr(hostAddr), .hostIorN(hostIorN), .hostIowN(hostIowN)
  );

  task automatic wrap_up();
    if (nFail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // a used-up wait bound ends the run as a failure
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      nFail++;
      wrap_up();
    end
  endtask : tmo

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // write: address and data offered together, each dropped once taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge core_clk);  // let an edge pass so bready is never dropped and raised in one step
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    bReady <= 1'b0;
    tmo(k, 50);
    chk("bresp", {30'h0, bResp}, {30'h0, er});
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge core_clk);  // let an edge pass so rready is never dropped and raised in one step
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    rReady <= 1'b0;
    d = rData;
    r = rResp;
    tmo(k, 50);
  endtask : axiRd

  // bounded wait for the controller to see n leading edges on a line
  task automatic waitFall(input int ln, input int n);
    int k;
    for (k = 0; k < 300 && host.falls[ln] < n; k++) @(posedge core_clk);
    tmo(k, 300);
  endtask : waitFall

  // main sequence: polled reset state, single routing, legacy map, shared pulse and irq_strobe_a
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          f;
    tick(4);
    rstn <= 1'b1;
    tick(1);
    portReq <= 4'hF;
    axiRd(`REG_CFG, d, r);
    chk("cfgReset", d, {8'h00, `CFG_RST});
    tick(3);
    chk("oePolled", {25'h0, irqOe}, 32'h0);
    axiRd(8'h10, d, r);
    chk("badRdResp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    chk("badRdData", d, 32'h0);
    axiWr(8'h10, 32'hFFFF_FFFF, `RESP_SLVERR);
    axiWr(`REG_STAT, 32'hFFFF_FFFF, `RESP_OKAY);
    axiRd(`REG_CFG, d, r);
    chk("cfgKept", d, {8'h00, `CFG_RST});
    // one selected port per pass, the rest fall to the disabled shared pool
    for (int p = 0; p < 4; p++) begin
      axiWr(`REG_CFG, 32'h0000_E4F0 | (32'h1 << p), `RESP_OKAY);
      tick(3);
      chk("singleOut", {25'h0, irqOut}, 32'h1 << p);
      chk("singleOe", {25'h0, irqOe}, 32'hF);
    end
    axiWr(`REG_CFG, 32'h0000_E401, `RESP_OKAY);
    tick(3);
    chk("noConnOe", {25'h0, irqOe}, 32'h0);
    axiWr(`REG_CFG, 32'h00F0_0000, `RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      portReq <= 4'h1 << p;
      tick(3);
      chk("legacyOut", {25'h0, irqOut}, 32'h1 << lm[p]);
      chk("legacyOe", {25'h0, irqOe}, 32'hF);
    end
    // port0 single on IRQ3 while port1 shares; line 0 also checks the single path is cut
    for (int i = 0; i < 7; i++) begin
      axiWr(`REG_CFG, 32'h0, `RESP_OKAY);
      portReq <= 4'h3;
      f = host.falls[i];
      axiWr(`REG_CFG, 32'h0008_E4F1 | (i << 16), `RESP_OKAY);
      waitFall(i, f + 1);
      tick(150);
      chk("onePulse", host.falls[i], f + 1);
      chk("pulseLow", host.lowLen[i], `PULSE_CYC);
      axiRd(`REG_STAT, d, r);
      chk("statBlocked", d, (((32'h1 << i) | 32'h1) << 7) | 32'h13);
      host.io(ra[(i + 1) % 7], 1'b0);
      tick(20);
      chk("wrongAddr", host.falls[i], f + 1);
      host.io(ra[i], i[0]);
      waitFall(i, f + 2);
      portReq <= 4'h1;
      tick(80);
      host.io(ra[i], 1'b0);
      tick(40);
      chk("poolOnly", host.falls[i], f + 2);
      axiRd(`REG_STAT, d, r);
      chk("statArmed", d, (((32'h1 << i) | 32'h1) << 7) | 32'h21);
    end
    wrap_up();
  end
endmodule : shared_irq_irq_strobe_a_logic_bench

//--- logic/shared_irq_irq_strobe_a_logic.sv
// interrupt routing for four serial ports: single lines and one shared line
// assumes host I/O strobes and address are asynchronous pins, port requests on core_clk
// Behaviour
// - separate single select for each port
// - selected port goes to single path
// - legacy-address ports never feed shared logic
// - all legacy: default port to line map
// - single lines 3,4,10,11 only when connected or all ports legacy
// - shared logic merges assigned port requests
// - fixed irq_strobe_a I/O address per line
// - I/O read at irq_strobe_a address rearms logic
// - still pending after irq_strobe_a pulses again
// - shared request is low pulse then high
// - no second pulse before irq_strobe_a
// - only non-single ports may be shared
// - shared logic drives exactly one line; with sharedLine 7 it drives none
// - shared line disables its single connection
// - shared ports never request single interrupts
// - all legacy enables every single path not taken by the shared line
// - polled and mixed operation both supported
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "irq_share_params.svh"

module shared_irq_irq_strobe_a_logic (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial port requests, active high
  input  wire logic [3:0]  portReq,
  // host I/O bus
  input  wire logic [15:0] hostAddr,
  input  wire logic        hostIorN,
  input  wire logic        hostIowN,
  // host IRQ lines, index 0..6 = IRQ3,4,10,11,12,14,15
  output logic [6:0]       irqOut,
  output logic [6:0]       irqOe
);

  irq_share_pkg::top_reg_t st_ff;
  irq_share_pkg::top_reg_t nxt_st;

  logic        allLeg;
  logic [3:0]  effSel;
  logic [3:0]  effConn;
  logic [7:0]  effLine;
  logic [3:0]  shMask;
  logic        pendShared;
  logic [3:0]  singleLvl;
  logic [3:0]  singleDrv;
  logic [15:0] rearmAddr;
  logic        iorEdge;
  logic        iowEdge;
  logic        rearmHit;
  logic        pulseLow;
  logic        pulseArmed;
  logic [31:0] cfgWord;
  logic [31:0] statWord;

  // effective routing; legacy ports are forced onto the single path
  assign allLeg  = &st_ff.cfg.legacy;
  assign effSel  = st_ff.cfg.singleSel | st_ff.cfg.legacy | {4{allLeg}};
  assign effConn = st_ff.cfg.lineConn | {4{allLeg}};
  assign effLine = allLeg ? `DFLT_MAP : st_ff.cfg.portLine;
  // a port on the single path can never reach the shared merge
  assign shMask     = ~effSel;
  assign pendShared = |(portReq & shMask);

  // one single line per generate entry
  for (genvar l = 0; l < `SINGLE_NUM; l++) begin : g_line
    logic [3:0] hit;
    for (genvar p = 0; p < 4; p++) begin : g_port
      assign hit[p] = effSel[p] && portReq[p] && (effLine[2*p +: 2] == 2'(l));
    end
    assign singleLvl[l] = |hit;
    // shared use of the same line takes it away from the single path
    assign singleDrv[l] = effConn[l] &&
                          !(st_ff.cfg.sharedEn && st_ff.cfg.sharedLine == 3'(l));
  end

  // irq_strobe_a address of the selected shared line
  always_comb begin
    case (st_ff.cfg.sharedLine)
      3'h0:    rearmAddr = `IRQ_STROBE_A_IRQ3;
      3'h1:    rearmAddr = `IRQ_STROBE_A_IRQ4;
      3'h2:    rearmAddr = `IRQ_STROBE_A_IRQ10;
      3'h3:    rearmAddr = `IRQ_STROBE_A_IRQ11;
      3'h4:    rearmAddr = `IRQ_STROBE_A_IRQ12;
      3'h5:    rearmAddr = `IRQ_STROBE_A_IRQ14;
      default: rearmAddr = `IRQ_STROBE_A_IRQ15;
    endcase
  end

  // strobe edges read only the second and third sync stages
  assign iorEdge  = !st_ff.iorSync[1] && st_ff.iorSync[2];
  assign iowEdge  = !st_ff.iowSync[1] && st_ff.iowSync[2];
  // read data is meaningless; a write is accepted too for service code that writes
  assign rearmHit = st_ff.cfg.sharedEn && (iorEdge || iowEdge) &&
                    (st_ff.addrS2 == rearmAddr);

  shared_pulse_gen u_pulse (
    .core_clk (core_clk),
    .rstn     (rstn),
    .enable   (st_ff.cfg.sharedEn),
    .pending  (pendShared),
    .irq_strobe_a    (rearmHit),
    .lineLow  (pulseLow),
    .armed    (pulseArmed)
  );

  assign cfgWord  = {8'h00, st_ff.cfg};
  assign statWord = {18'h00000, st_ff.irqOut, pulseLow, pulseArmed, pendShared, portReq};

  // bus slave, synchronisers and line drivers
  always_comb begin
    logic [31:0] merged;
    merged = cfgWord;
    nxt_st = st_ff;
    // host pins pass two flops, the third only delays for edge detection
    nxt_st.iorSync = {st_ff.iorSync[1:0], hostIorN};
    nxt_st.iowSync = {st_ff.iowSync[1:0], hostIowN};
    nxt_st.addrS1  = hostAddr;
    nxt_st.addrS2  = st_ff.addrS1;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_ff.awReady) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wReady) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = s_axi_wdata;
      nxt_st.wStrb = s_axi_wstrb;
    end
    if (st_ff.bValid && s_axi_bready) begin
      nxt_st.bValid = 1'b0;
    end
    if (st_ff.awHeld && st_ff.wHeld && !st_ff.bValid) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld  = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp  = `RESP_OKAY;
      if (st_ff.awAddr == `REG_CFG) begin
        for (int b = 0; b < 4; b++) begin
          if (st_ff.wStrb[b]) begin
            merged[8*b +: 8] = st_ff.wData[8*b +: 8];
          end
        end
        nxt_st.cfg = merged[23:0];
      end else if (st_ff.awAddr == `REG_STAT) begin
        nxt_st.bResp = `RESP_OKAY;   // status is read only, write dropped
      end else begin
        nxt_st.bResp = `RESP_SLVERR;
      end
    end
    nxt_st.awReady = !nxt_st.awHeld && !nxt_st.bValid;
    nxt_st.wReady  = !nxt_st.wHeld && !nxt_st.bValid;

    // read channel: answer one cycle after the address is taken
    if (st_ff.rValid && s_axi_rready) begin
      nxt_st.rValid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arReady) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp  = `RESP_OKAY;
      if (s_axi_araddr == `REG_CFG) begin
        nxt_st.rData = cfgWord;
      end else if (s_axi_araddr == `REG_STAT) begin
        nxt_st.rData = statWord;
      end else begin
        nxt_st.rData = 32'h00000000;
        nxt_st.rResp = `RESP_SLVERR;
      end
    end
    nxt_st.arReady = !nxt_st.rValid;

    // line drivers; nothing drives with all disabled, which is polled operation
    for (int i = 0; i < `LINE_NUM; i++) begin
      nxt_st.irqOut[i] = 1'b0;
      nxt_st.irqOe[i]  = 1'b0;
      if (st_ff.cfg.sharedEn && st_ff.cfg.sharedLine == 3'(i)) begin
        nxt_st.irqOe[i]  = 1'b1;
        nxt_st.irqOut[i] = !pulseLow;
      end else if (i < `SINGLE_NUM) begin
        if (singleDrv[i[1:0]]) begin
          nxt_st.irqOe[i]  = 1'b1;
          nxt_st.irqOut[i] = singleLvl[i[1:0]];
        end
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff         <= '0;
      st_ff.cfg     <= `CFG_RST;
      st_ff.iorSync <= 3'h7;
      st_ff.iowSync <= 3'h7;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awReady;
  assign s_axi_wready  = st_ff.wReady;
  assign s_axi_bvalid  = st_ff.bValid;
  assign s_axi_bresp   = st_ff.bResp;
  assign s_axi_arready = st_ff.arReady;
  assign s_axi_rvalid  = st_ff.rValid;
  assign s_axi_rdata   = st_ff.rData;
  assign s_axi_rresp   = st_ff.rResp;
  assign irqOut        = st_ff.irqOut;
  assign irqOe         = st_ff.irqOe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_all_legacy: assert property (allLeg && !st_ff.cfg.sharedEn |=> irqOe[3:0] == 4'hF)
    else $error("all legacy did not enable single lines");
  chk_shared_oe: assert property (st_ff.cfg.sharedEn |=> irqOe[$past(st_ff.cfg.sharedLine)])
    else $error("shared line not driven");
  chk_shared_level: assert property (st_ff.cfg.sharedEn && !pulseLow
                                     |=> irqOut[$past(st_ff.cfg.sharedLine)])
    else $error("shared line not high between pulses");
  chk_share_excl: assert property (st_ff.cfg.sharedEn && st_ff.cfg.sharedLine == 3'h0
                                   |=> irqOut[0] == !$past(pulseLow))
    else $error("single source on shared line");
  chk_irq_strobe_a_read: assert property (rearmHit && !pulseArmed && !pulseLow |=> pulseArmed)
    else $error("irq_strobe_a access did not irq_strobe_a");
  chk_legacy_excl: assert property ((shMask & st_ff.cfg.legacy) == 4'h0)
    else $error("legacy port in shared merge");
  chk_unconnected: assert property (!st_ff.cfg.sharedEn && !allLeg && st_ff.cfg.lineConn == 4'h0
                                    |=> irqOe[3:0] == 4'h0)
    else $error("unconnected single line driven");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
                                   |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule : shared_irq_irq_strobe_a_logic

//--- logic/shared_pulse_gen.sv
// shared request pulse generator: one low pulse, then blocked until rearmed
// assumes pending and irq_strobe_a come from logic on core_clk
`timescale 1ns/1ps
`include "irq_share_params.svh"

module shared_pulse_gen (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic enable,
  input  wire logic pending,
  input  wire logic irq_strobe_a,
  output logic      lineLow,
  output logic      armed
);

  localparam int PW = `PULSE_CYC;

  irq_share_pkg::pulse_reg_t st_ff;
  irq_share_pkg::pulse_reg_t nxt_st;

  // next state; a irq_strobe_a during the pulse itself is ignored
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.st)
      irq_share_pkg::PS_ARMED: begin
        if (enable && pending) begin
          nxt_st.st  = irq_share_pkg::PS_PULSE;
          nxt_st.cnt = '0;
        end
      end
      irq_share_pkg::PS_PULSE: begin
        if (st_ff.cnt == `PULSE_CW'(`PULSE_CYC - 1)) begin
          nxt_st.st = irq_share_pkg::PS_BLOCKED;
        end else begin
          nxt_st.cnt = st_ff.cnt + `PULSE_CW'(1);
        end
      end
      default: begin
        if (irq_strobe_a) begin
          nxt_st.st = irq_share_pkg::PS_ARMED;
        end
      end
    endcase
    if (!enable) begin
      nxt_st.st = irq_share_pkg::PS_ARMED;  // idle line stays high, ready to go
    end
    nxt_st.low   = (nxt_st.st == irq_share_pkg::PS_PULSE);
    nxt_st.armed = (nxt_st.st == irq_share_pkg::PS_ARMED);
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff <= '{st: irq_share_pkg::PS_ARMED, cnt: '0, low: 1'b0, armed: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lineLow = st_ff.low;
  assign armed   = st_ff.armed;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_pulse_width: assert property ($rose(lineLow) |-> ##[PW:PW] !lineLow)
    else $error("shared pulse width wrong");
  chk_pulse_low: assert property ($rose(lineLow) |-> lineLow [*8])
    else $error("shared pulse ended early");
  chk_no_repulse: assert property (!armed && !lineLow && !irq_strobe_a |=> !lineLow)
    else $error("pulse without irq_strobe_a");
  chk_irq_strobe_a_repulse: assert property (armed && enable && pending |=> lineLow)
    else $error("pending request not pulsed");

endmodule : shared_pulse_gen
